//--- inc/acr_pkg.sv
// Purpose: Shared constants and types of the accelerometer system control registers
// Assumes: 50 MHz system clock
// Notes:   Register offsets, field positions, reset values and timing constants
package acr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h2a;
	localparam logic [7:0] ADDR_CTRL_TWO = 8'h2b;
	localparam logic [7:0] ADDR_X_MSB    = 8'h01;
	localparam logic [7:0] ADDR_Z_MSB    = 8'h05;
	localparam logic [7:0] STEP_NORMAL   = 8'h01;
	localparam logic [7:0] STEP_FAST     = 8'h02;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int C1_ACTIVE   = 0;
	localparam int C1_FREAD    = 1;
	localparam int C1_LNOISE   = 2;
	localparam int C1_DR_LSB   = 3;
	localparam int C1_ASLP_LSB = 6;
	localparam int C2_MODS_LSB = 0;
	localparam int C2_SLPE     = 2;
	localparam int C2_SMOD_LSB = 3;
	localparam int C2_RST      = 6;
	localparam int C2_ST       = 7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] DR_RST_VAL   = 3'h1;
	localparam logic [1:0] ASLP_RST_VAL = 2'h0;
	localparam logic [1:0] MODS_RST_VAL = 2'h0;
	localparam logic [7:0] RD_ZERO      = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 20;
	localparam int BASE_PERIOD_NS = 1250000;   // 800 Hz sample period
	localparam int BASE_PERIOD_CYC = BASE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int BOOT_TIME_NS   = 1000000;   // Soft reset boot time
	localparam int BOOT_TIME_CYC  = BOOT_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		MODE_STANDBY,
		MODE_WAKE,
		MODE_SLEEP,
		MODE_BOOT
	} acr_mode_e;

	// Period multiplier, as a left shift of the 800 Hz period
	function automatic logic [3:0] acr_odr_shift(input logic [2:0] code);
		logic [3:0] s;
		s = 4'h0;
		case (code)
			3'h0: s = 4'h0;
			3'h1: s = 4'h1;
			3'h2: s = 4'h2;
			3'h3: s = 4'h3;
			3'h4: s = 4'h4;
			3'h5: s = 4'h6;
			3'h6: s = 4'h7;
			default: s = 4'h9;
		endcase
		return s;
	endfunction : acr_odr_shift

	function automatic logic [3:0] acr_sleep_shift(input logic [1:0] code);
		logic [3:0] s;
		s = 4'h4;
		case (code)
			2'h0: s = 4'h4;
			2'h1: s = 4'h6;
			2'h2: s = 4'h7;
			default: s = 4'h9;
		endcase
		return s;
	endfunction : acr_sleep_shift

endpackage : acr_pkg

//--- rtl/acr_tick_div.sv
// Purpose: Sample rate divider, one-cycle tick every period cycles
// Assumes: Period of at least one cycle
// Notes:   Restarts from zero whenever disabled
`timescale 1ns/1ns
module acr_tick_div (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        en,
	input  wire logic [31:0] period,
	output logic             tick
);
	logic [31:0] cnt_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 32'h0;
			tick  <= 1'b0;
		end else if (!en) begin
			cnt_r <= 32'h0;
			tick  <= 1'b0;
		end else if (cnt_r >= period - 32'h1) begin
			cnt_r <= 32'h0;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 32'h1;
			tick  <= 1'b0;
		end
	end
endmodule : acr_tick_div

//--- rtl/acr_sys_ctrl.sv
// Purpose: System control register pair of a three-axis accelerometer
// Assumes: Serial engine on sys_clk presents one-cycle read and write strobes
// Notes:   Also supplies the burst pointer step and the sampling rate tick
//
// Overview of operation
// - The sleep poll code picks 50, 12.5, 6.25 or 1.56 Hz for codes 0 to 3.
// - In auto-sleep the whole system samples at the sleep poll rate instead of the data rate.
// - The output rate code picks 800 down to 1.5625 Hz for codes 0 to 7 and resets to 1.
// - The active bit selects Standby at 0 and Active at 1 and resets to Standby.
// - The reduced-noise bit doubles gain and limits full scale to 4 g.
// - Fast-read limits output to the high byte and burst addressing skips the X and Y low bytes.
// - With fast-read, a 3-byte burst from the X high byte returns the three high bytes.
// - The self-test bit enables self-test and shifts every axis output, 0 disables it.
// - Soft reset goes to Standby, reloads defaults, self-clears at boot end; host waits 1 ms.
// - The auto-sleep enable bit forbids sleep transitions at 0 and allows them at 1.
`timescale 1ns/1ns
module acr_sys_ctrl
	import acr_pkg::*;
#(
	parameter int unsigned BASE_CYC = acr_pkg::BASE_PERIOD_CYC,
	parameter int unsigned BOOT_CYC = acr_pkg::BOOT_TIME_CYC
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic [7:0]            reg_addr,
	input  wire logic                  reg_wr_en,
	input  wire logic [7:0]            reg_wr_data,
	input  wire logic                  reg_rd_en,
	input  wire logic                  sleep_req,
	output logic [7:0]                 reg_rd_data,
	output logic [7:0]                 burst_next_addr,
	output logic                       active_mode,
	output logic                       sleep_mode,
	output logic                       boot_busy,
	output logic                       sample_tick,
	output logic                       gain_x2,
	output logic                       msb_only,
	output logic                       self_test_enable,
	output logic                       auto_sleep_en,
	output logic [1:0]                 sleep_osr_mode,
	output logic [1:0]                 wake_osr_mode
);
	import acr_pkg::*;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_s1_r;
	logic rst_sync_n;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_s1_r   <= 1'b1;
			rst_sync_n <= rst_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	acr_mode_e   mode_r;
	logic        active_r;
	logic        fast_read_r;
	logic        reduced_noise_r;
	logic [2:0]  output_rate_sel_r;
	logic [1:0]  aslp_rate_r;
	logic [1:0]  mods_r;
	logic        slpe_r;
	logic [1:0]  smods_r;
	logic        self_test_r;
	logic [31:0] boot_cnt_r;
	logic        wr_one;
	logic        wr_two;
	logic        soft_rst;
	logic        boot_done;

	// Writes are dropped during boot; reads are still served and show the boot flag
	assign wr_one    = reg_wr_en && (reg_addr == ADDR_CTRL_ONE) && (mode_r != MODE_BOOT);
	assign wr_two    = reg_wr_en && (reg_addr == ADDR_CTRL_TWO) && (mode_r != MODE_BOOT);
	assign soft_rst  = wr_two && reg_wr_data[C2_RST];
	assign boot_done = (mode_r == MODE_BOOT) && (boot_cnt_r >= BOOT_CYC - 1);

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			active_r <= 1'b0;
		end else if (soft_rst || boot_done) begin
			active_r <= 1'b0;
		end else if (wr_one) begin
			active_r <= reg_wr_data[C1_ACTIVE];
		end
	end

	// Other control-one fields only take writes in Standby; a write while active keeps them
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fast_read_r       <= 1'b0;
			reduced_noise_r   <= 1'b0;
			output_rate_sel_r <= DR_RST_VAL;
			aslp_rate_r       <= ASLP_RST_VAL;
		end else if (boot_done) begin
			fast_read_r       <= 1'b0;
			reduced_noise_r   <= 1'b0;
			output_rate_sel_r <= DR_RST_VAL;
			aslp_rate_r       <= ASLP_RST_VAL;
		end else if (wr_one && !active_r) begin
			fast_read_r       <= reg_wr_data[C1_FREAD];
			reduced_noise_r   <= reg_wr_data[C1_LNOISE];
			output_rate_sel_r <= reg_wr_data[C1_DR_LSB +: 3];
			aslp_rate_r       <= reg_wr_data[C1_ASLP_LSB +: 2];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mods_r      <= MODS_RST_VAL;
			slpe_r      <= 1'b0;
			smods_r     <= MODS_RST_VAL;
			self_test_r <= 1'b0;
		end else if (soft_rst || boot_done) begin
			mods_r      <= MODS_RST_VAL;
			slpe_r      <= 1'b0;
			smods_r     <= MODS_RST_VAL;
			self_test_r <= 1'b0;
		end else if (wr_two) begin
			mods_r      <= reg_wr_data[C2_MODS_LSB +: 2];
			slpe_r      <= reg_wr_data[C2_SLPE];
			smods_r     <= reg_wr_data[C2_SMOD_LSB +: 2];
			self_test_r <= reg_wr_data[C2_ST];
		end
	end

	// ----------------------------------------------------------------
	// System mode
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			boot_cnt_r <= 32'h0;
		end else if (mode_r == MODE_BOOT) begin
			boot_cnt_r <= boot_cnt_r + 32'h1;
		end else begin
			boot_cnt_r <= 32'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mode_r <= MODE_STANDBY;
		end else if (soft_rst) begin
			mode_r <= MODE_BOOT;
		end else begin
			case (mode_r)
				MODE_BOOT: begin
					if (boot_done) begin
						mode_r <= MODE_STANDBY;
					end
				end
				MODE_STANDBY: begin
					if (active_r) begin
						mode_r <= MODE_WAKE;
					end
				end
				MODE_WAKE: begin
					if (!active_r) begin
						mode_r <= MODE_STANDBY;
					end else if (slpe_r && sleep_req) begin
						mode_r <= MODE_SLEEP;
					end
				end
				MODE_SLEEP: begin
					if (!active_r) begin
						mode_r <= MODE_STANDBY;
					end else if (!slpe_r || !sleep_req) begin
						mode_r <= MODE_WAKE;
					end
				end
				default: mode_r <= MODE_STANDBY;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sampling rate
	// ----------------------------------------------------------------
	logic [3:0]  rate_shift;
	logic [31:0] rate_period;
	logic        tick_raw;
	logic        sampling;

	// Sleep overrides the selected data rate for every block
	assign rate_shift  = (mode_r == MODE_SLEEP) ? acr_sleep_shift(aslp_rate_r)
	                                            : acr_odr_shift(output_rate_sel_r);
	assign rate_period = BASE_CYC << rate_shift;
	assign sampling    = (mode_r == MODE_WAKE) || (mode_r == MODE_SLEEP);

	acr_tick_div u_div (
		.clk    (sys_clk),
		.rst_n  (rst_sync_n),
		.en     (sampling),
		.period (rate_period),
		.tick   (tick_raw)
	);

	// ----------------------------------------------------------------
	// Read port and burst pointer
	// ----------------------------------------------------------------
	logic [7:0] rd_nxt;
	logic [7:0] ptr_nxt;

	always_comb begin
		rd_nxt = RD_ZERO;
		case (reg_addr)
			ADDR_CTRL_ONE: begin
				rd_nxt[C1_ACTIVE]        = active_r;
				rd_nxt[C1_FREAD]         = fast_read_r;
				rd_nxt[C1_LNOISE]        = reduced_noise_r;
				rd_nxt[C1_DR_LSB +: 3]   = output_rate_sel_r;
				rd_nxt[C1_ASLP_LSB +: 2] = aslp_rate_r;
			end
			ADDR_CTRL_TWO: begin
				rd_nxt[C2_MODS_LSB +: 2] = mods_r;
				rd_nxt[C2_SLPE]          = slpe_r;
				rd_nxt[C2_SMOD_LSB +: 2] = smods_r;
				rd_nxt[C2_RST]           = (mode_r == MODE_BOOT);
				rd_nxt[C2_ST]            = self_test_r;
			end
			default: rd_nxt = RD_ZERO;
		endcase
	end

	// X and Y low bytes sit at odd offsets plus one, so a step of two skips them
	always_comb begin
		ptr_nxt = reg_addr + STEP_NORMAL;
		if (fast_read_r && (reg_addr >= ADDR_X_MSB) && (reg_addr < ADDR_Z_MSB)) begin
			ptr_nxt = reg_addr + STEP_FAST;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rd_data     <= RD_ZERO;
			burst_next_addr <= RD_ZERO;
		end else if (reg_rd_en) begin
			reg_rd_data     <= rd_nxt;
			burst_next_addr <= ptr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			active_mode      <= 1'b0;
			sleep_mode       <= 1'b0;
			boot_busy        <= 1'b0;
			sample_tick      <= 1'b0;
			gain_x2          <= 1'b0;
			msb_only         <= 1'b0;
			self_test_enable <= 1'b0;
			auto_sleep_en    <= 1'b0;
			sleep_osr_mode   <= MODS_RST_VAL;
			wake_osr_mode    <= MODS_RST_VAL;
		end else begin
			active_mode      <= (mode_r == MODE_WAKE) || (mode_r == MODE_SLEEP);
			sleep_mode       <= (mode_r == MODE_SLEEP);
			boot_busy        <= (mode_r == MODE_BOOT);
			sample_tick      <= tick_raw;
			gain_x2          <= reduced_noise_r;
			msb_only         <= fast_read_r;
			self_test_enable <= self_test_r;
			auto_sleep_en    <= slpe_r;
			sleep_osr_mode   <= smods_r;
			wake_osr_mode    <= mods_r;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_sync_n);

	standby_guard_a: assert property (active_r && wr_one |=> $stable(output_rate_sel_r))
		else $error("rate changed while active");
	sleep_rate_a: assert property (mode_r == MODE_SLEEP && aslp_rate_r == 2'h0
		|-> rate_period == (BASE_CYC << 4))
		else $error("sleep poll period wrong");
	sleep_over_a: assert property (mode_r == MODE_SLEEP |=> sleep_mode)
		else $error("sleep not shown");
	odr_period_a: assert property (mode_r == MODE_WAKE && output_rate_sel_r == 3'h7
		|-> rate_period == (BASE_CYC << 9))
		else $error("data rate period wrong");
	active_follow_a: assert property (wr_one && !soft_rst
		|=> active_r == $past(reg_wr_data[C1_ACTIVE]))
		else $error("active bit not taken");
	gain_out_a: assert property (reduced_noise_r |-> ##1 gain_x2)
		else $error("gain not doubled");
	fast_step_a: assert property (reg_rd_en && fast_read_r && reg_addr == ADDR_X_MSB
		|=> burst_next_addr == ADDR_X_MSB + STEP_FAST)
		else $error("low byte not skipped");
	self_test_a: assert property (wr_two && !reg_wr_data[C2_ST] |=> !self_test_r)
		else $error("self test not cleared");
	soft_boot_a: assert property (soft_rst |=> mode_r == MODE_BOOT && !active_r)
		else $error("soft reset not entered");
	no_sleep_a: assert property (!slpe_r |-> ##1 mode_r != MODE_SLEEP)
		else $error("slept while disabled");

	wake_c:  cover property (mode_r == MODE_STANDBY ##1 mode_r == MODE_WAKE);
	sleep_c: cover property (mode_r == MODE_WAKE ##1 mode_r == MODE_SLEEP);
	boot_c:  cover property (boot_done);
	fast_c:  cover property (reg_rd_en && fast_read_r && reg_addr == ADDR_Z_MSB);
endmodule : acr_sys_ctrl

//--- bench/acr_host_model.sv
// Purpose: Host side model issuing register strobes to the control pair
// Assumes: Requests change just after a sys_clk rising edge
// Notes:   Idle address shows the inverted last address; data is inverted after a write, kept after a read
`timescale 1ns/1ns
module acr_host_model (
	input  wire logic       sys_clk,
	input  wire logic [7:0] reg_rd_data,
	input  wire logic [7:0] burst_next_addr,
	output logic [7:0]      reg_addr,
	output logic            reg_wr_en,
	output logic [7:0]      reg_wr_data,
	output logic            reg_rd_en
);
	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	initial begin
		reg_addr    = 8'h00;
		reg_wr_en   = 1'b0;
		reg_wr_data = 8'h00;
		reg_rd_en   = 1'b0;
	end

	// Callers set non-active control-one fields in Standby; the 8'h08 and 8'h00 writes while active leave them unchanged
	// No FIFO here, so fast-read changes always see FIFO mode zero
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr    <= a;
		reg_wr_data <= d;
		reg_wr_en   <= 1'b1;
		@(posedge sys_clk);
		reg_wr_en   <= 1'b0;
		reg_addr    <= ~a;
		reg_wr_data <= ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [7:0] nx);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_rd_en <= 1'b1;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		reg_addr  <= ~a;
		#1;
		d  = reg_rd_data;
		nx = burst_next_addr;
	endtask : rd

	// Quiet bus for the boot time after a soft reset
	task automatic boot_wait(input int cyc);
		repeat (cyc + 2) @(posedge sys_clk);
	endtask : boot_wait
endmodule : acr_host_model

//--- bench/testbench.sv
// Purpose: Self-checking bench of the system control register pair
// Assumes: Short base and boot counts so the run stays brief
// Notes:   Each scenario is its own task; tick gap expectations come from the rate tables
`timescale 1ns/1ns
module testbench;
	import acr_pkg::*;
	localparam int BASE = 4;
	localparam int BOOT = 8;
	logic       sys_clk, rst_n, sleep_req, reg_wr_en, reg_rd_en;
	logic [7:0] reg_addr, reg_wr_data, reg_rd_data, burst_next_addr;
	logic       active_mode, sleep_mode, boot_busy, sample_tick;
	logic       gain_x2, msb_only, self_test_enable, auto_sleep_en;
	logic [1:0] sleep_osr_mode, wake_osr_mode;
	int         fails = 0;
	int         n_tests = 0;
	int         dr_sh[8] = '{0, 1, 2, 3, 4, 6, 7, 9};
	int         sl_sh[4] = '{4, 6, 7, 9};

	// ----------------------------------------------------------------
	// Clock, reset and instances
	// ----------------------------------------------------------------
	initial sys_clk = 1'b0;
	always #10 sys_clk = ~sys_clk;

	acr_sys_ctrl #(.BASE_CYC(BASE), .BOOT_CYC(BOOT)) acr_sys_ctrl_i (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .sleep_req(sleep_req),
		.reg_rd_data(reg_rd_data), .burst_next_addr(burst_next_addr),
		.active_mode(active_mode), .sleep_mode(sleep_mode), .boot_busy(boot_busy),
		.sample_tick(sample_tick), .gain_x2(gain_x2), .msb_only(msb_only),
		.self_test_enable(self_test_enable), .auto_sleep_en(auto_sleep_en),
		.sleep_osr_mode(sleep_osr_mode), .wake_osr_mode(wake_osr_mode));

	acr_host_model acr_host_model_i (
		.sys_clk(sys_clk), .reg_rd_data(reg_rd_data), .burst_next_addr(burst_next_addr),
		.reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
		.reg_rd_en(reg_rd_en));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic timeout();
		fails++;
		$display("[ERR] wait_bound expected done seen hang");
		give_verdict();
	endtask : timeout

	task automatic settle();
		repeat (4) @(posedge sys_clk);
		#1;
	endtask : settle

	task automatic rdchk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] nx);
		logic [7:0] sd, snx;
		acr_host_model_i.rd(a, sd, snx);
		check("read_data", {24'h0, sd}, {24'h0, d});
		check("next_addr", {24'h0, snx}, {24'h0, nx});
	endtask : rdchk

	// Which 0 waits on boot_busy, 1 on sleep_mode; bounded
	task automatic wait_flag(input int which, input logic val);
		int c;
		c = 0;
		while (((which == 0) ? boot_busy : sleep_mode) !== val && c < 100) begin
			@(posedge sys_clk);
			#1;
			c++;
		end
		if (c >= 100) timeout();
	endtask : wait_flag

	// Gap from the second to the third tick; earlier ones may straddle a rate change
	task automatic tick_gap(output logic [31:0] p);
		int c;
		c = 0;
		for (int k = 0; k < 3; k++) begin
			c = 0;
			do begin
				@(posedge sys_clk);
				#1;
				c++;
			end while (sample_tick !== 1'b1 && c < 5000);
			if (c >= 5000) timeout();
		end
		p = c;
	endtask : tick_gap

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		check("active_mode", active_mode, 0);
		rdchk(8'h2a, 8'h08, 8'h2b);
		rdchk(8'h2b, 8'h00, 8'h2c);
		rdchk(8'h10, 8'h00, 8'h11);
	endtask : t_reset

	task automatic t_fields();
		acr_host_model_i.wr(8'h2a, 8'h9e);
		settle();
		rdchk(8'h2a, 8'h9e, 8'h2b);
		check("gain_x2", gain_x2, 1);
		check("msb_only", msb_only, 1);
		rdchk(8'h01, 8'h00, 8'h03);
		rdchk(8'h03, 8'h00, 8'h05);
		rdchk(8'h05, 8'h00, 8'h06);
		acr_host_model_i.wr(8'h2a, 8'h08);
		settle();
		rdchk(8'h01, 8'h00, 8'h02);
		check("gain_x2", gain_x2, 0);
	endtask : t_fields

	task automatic t_rates();
		logic [31:0] p;
		for (int k = 0; k < 8; k++) begin
			acr_host_model_i.wr(8'h2a, {2'b00, 3'(k), 3'b000});
			acr_host_model_i.wr(8'h2a, {2'b00, 3'(k), 3'b001});
			tick_gap(p);
			check("odr_gap", p, 32'(BASE << dr_sh[k]));
			check("active_mode", active_mode, 1);
			acr_host_model_i.wr(8'h2a, 8'h08);
			settle();
			check("active_mode", active_mode, 0);
		end
	endtask : t_rates

	task automatic t_sleep();
		logic [31:0] p;
		acr_host_model_i.wr(8'h2b, 8'h04);
		settle();
		check("auto_sleep_en", auto_sleep_en, 1);
		@(posedge sys_clk) sleep_req <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			acr_host_model_i.wr(8'h2a, {2'(k), 6'h00});
			acr_host_model_i.wr(8'h2a, {2'(k), 6'h01});
			wait_flag(1, 1'b1);
			tick_gap(p);
			check("sleep_gap", p, 32'(BASE << sl_sh[k]));
			acr_host_model_i.wr(8'h2a, 8'h00);
		end
		// Sleep request must be ignored with auto-sleep off
		acr_host_model_i.wr(8'h2b, 8'h00);
		acr_host_model_i.wr(8'h2a, 8'h01);
		repeat (10) @(posedge sys_clk);
		#1;
		check("sleep_mode", sleep_mode, 0);
		acr_host_model_i.wr(8'h2a, 8'h08);
		@(posedge sys_clk) sleep_req <= 1'b0;
	endtask : t_sleep

	task automatic t_ctrl2();
		acr_host_model_i.wr(8'h2b, 8'hbb);
		settle();
		rdchk(8'h2b, 8'h9b, 8'h2c);
		check("self_test", self_test_enable, 1);
		check("osr_modes", {sleep_osr_mode, wake_osr_mode}, 4'hf);
		acr_host_model_i.wr(8'h2b, 8'h00);
		settle();
		check("self_test", self_test_enable, 0);
	endtask : t_ctrl2

	task automatic t_softrst();
		acr_host_model_i.wr(8'h2a, 8'h9e);
		acr_host_model_i.wr(8'h2a, 8'h9f);
		acr_host_model_i.wr(8'h2b, 8'h40);
		wait_flag(0, 1'b1);
		check("active_mode", active_mode, 0);
		// Deliberate early write, which boot must refuse
		acr_host_model_i.wr(8'h2a, 8'h02);
		rdchk(8'h2b, 8'h40, 8'h2c);
		wait_flag(0, 1'b0);
		acr_host_model_i.boot_wait(BOOT);
		rdchk(8'h2a, 8'h08, 8'h2b);
		rdchk(8'h2b, 8'h00, 8'h2c);
	endtask : t_softrst

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n     = 1'b0;
		sleep_req = 1'b0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_reset();
		t_fields();
		t_rates();
		t_sleep();
		t_ctrl2();
		t_softrst();
		give_verdict();
	end
endmodule : testbench
